/* File: plfc_pkg.sv */
package plfc_pkg;

  // completion and fault codes
  localparam logic [7:0] CODE_OK = 8'h00;
  localparam logic [7:0] CODE_MIN = 8'h50;
  localparam logic [7:0] CODE_MAX = 8'h60;
  localparam logic [7:0] CODE_DETAIL = 8'h5B;
  localparam logic [7:0] CODE_FALLBACK = 8'h50;
  localparam logic [7:0] DETAIL_MIN = 8'h10;
  localparam logic [7:0] DETAIL_MAX = 8'h18;
  localparam logic [7:0] DETAIL_FALLBACK = 8'h10;
  localparam logic [7:0] PAD_BYTE = 8'h00;

  // fixed command field values
  localparam logic [7:0] STATION_LOCAL = 8'hFF;
  localparam logic [7:0] SUB_BIT_READ = 8'h00;
  localparam logic [15:0] DEV_CODE_RELAY = 16'h4D20;

  // text characters
  localparam logic [7:0] ASC_ZERO = 8'h30;
  localparam logic [7:0] ASC_ONE = 8'h31;
  localparam logic [7:0] ASC_NINE = 8'h39;
  localparam logic [7:0] ASC_A = 8'h41;
  localparam logic [7:0] ASC_F = 8'h46;
  localparam logic [7:0] ASC_A_OFS = 8'h37;
  localparam logic [3:0] NIB_TEN = 4'hA;

  // command byte slots, in binary wire order
  localparam int CMD_BYTES = 12;
  localparam logic [3:0] SLOT_SUB = 4'h0;
  localparam logic [3:0] SLOT_STN = 4'h1;
  localparam logic [3:0] SLOT_TMR_L = 4'h2;
  localparam logic [3:0] SLOT_TMR_H = 4'h3;
  localparam logic [3:0] SLOT_HEAD0 = 4'h4;
  localparam logic [3:0] SLOT_HEAD1 = 4'h5;
  localparam logic [3:0] SLOT_HEAD2 = 4'h6;
  localparam logic [3:0] SLOT_HEAD3 = 4'h7;
  localparam logic [3:0] SLOT_DEV_L = 4'h8;
  localparam logic [3:0] SLOT_DEV_H = 4'h9;
  localparam logic [3:0] SLOT_CNT = 4'hA;
  localparam logic [3:0] SLOT_PAD = 4'hB;

  // monitoring timer step
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS = 250;

  typedef enum logic [1:0] {
    MODE_BIT1 = 2'b00,
    MODE_BIT16 = 2'b01,
    MODE_WORD = 2'b10
  } plfc_mode_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SUB = 3'b001,
    S_CODE = 3'b010,
    S_FAULT = 3'b011,
    S_PAD = 3'b100,
    S_DATA = 3'b101
  } plfc_tx_state_type;

endpackage

/* File: plfc_hex_if.sv */
`timescale 1ns/1ps
interface plfc_hex_if;
  logic [7:0] byte_in;
  logic [15:0] chars_out;
  logic [15:0] chars_in;
  logic [7:0] byte_out;
  logic ok;
  modport user (output byte_in, output chars_in, input chars_out,
                input byte_out, input ok);
  modport unit (input byte_in, input chars_in, output chars_out,
                output byte_out, output ok);
endinterface

/* File: plfc_hex_unit.sv */
`timescale 1ns/1ps
module plfc_hex_unit (
  plfc_hex_if.unit hx
);

  function automatic logic [7:0] nib2asc(input logic [3:0] n);
    if (n < plfc_pkg::NIB_TEN)
      nib2asc = plfc_pkg::ASC_ZERO + {4'h0, n};
    else
      nib2asc = plfc_pkg::ASC_A_OFS + {4'h0, n};
  endfunction

  // upper-case only: lower-case hex is flagged, not folded
  function automatic logic [4:0] asc2nib(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    asc2nib = 5'h00;
    if (c >= plfc_pkg::ASC_ZERO && c <= plfc_pkg::ASC_NINE) begin
      d = c - plfc_pkg::ASC_ZERO;
      asc2nib = {1'h1, d[3:0]};
    end else if (c >= plfc_pkg::ASC_A && c <= plfc_pkg::ASC_F) begin
      d = c - plfc_pkg::ASC_A_OFS;
      asc2nib = {1'h1, d[3:0]};
    end
  endfunction

  logic [4:0] hi_nib;
  logic [4:0] lo_nib;

  assign hx.chars_out = {nib2asc(hx.byte_in[7:4]), nib2asc(hx.byte_in[3:0])};
  assign hi_nib = asc2nib(hx.chars_in[15:8]);
  assign lo_nib = asc2nib(hx.chars_in[7:0]);
  assign hx.byte_out = {hi_nib[3:0], lo_nib[3:0]};
  assign hx.ok = hi_nib[4] & lo_nib[4];

endmodule

/* File: plfc_link_field_codec.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - completion code 00H on success, otherwise a value 50H..60H.
// - binary sends codes as raw bytes; text as two hex characters.
// - after code 5BH comes a detail code 10H..18H, then 00H.
// - detail code only with 5BH, encoded per active data code.
// - binary or text chosen by stored setting, not per frame.
// - binary multi-byte fields travel low byte first.
// - text fields are hex characters, most significant digit first.
// - station field for the attached controller is FFH.
// - bit batch read in single points has subheader 00H, first byte.
// - binary read: timer, head number 4 bytes, device code, count.
// - text single-point bits: one character each, 31H on, 30H off.
// - text 16-point bits: four hex characters, highest bit first.
// - text words: four hex characters, top nibble first, in sequence.
// - word contents return as raw bit patterns, never interpreted.
// - timer counts 250 ms steps; zero waits forever.
// - binary single-point bits: one nibble each, 1 on, 0 off.
module plfc_link_field_codec #(
  parameter int TICK_CYCLES =
    plfc_pkg::CLK_HZ / plfc_pkg::MS_PER_S * plfc_pkg::TICK_MS,
  parameter int POINT_W = 9
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic DATA_CODE_ASCII,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_LAST,
  output logic CMD_VALID,
  output logic CMD_ERR,
  output logic [7:0] CMD_SUBHDR,
  output logic [7:0] CMD_STATION,
  output logic [15:0] CMD_TIMER,
  output logic [31:0] CMD_HEAD,
  output logic [15:0] CMD_DEVICE,
  output logic [7:0] CMD_POINTS,
  output logic TIMEOUT,
  input wire logic RESP_START,
  input wire logic [7:0] RESP_SUBHDR,
  input wire logic [7:0] RESP_CODE,
  input wire logic [7:0] RESP_DETAIL,
  input wire logic [1:0] RESP_MODE,
  input wire logic [POINT_W-1:0] RESP_POINTS,
  output logic RESP_BUSY,
  output logic DATA_REQ,
  input wire logic DATA_VALID,
  input wire logic [15:0] DATA_WORD,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic [7:0] TX_DATA,
  output logic TX_LAST
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  plfc_hex_if hx();
  plfc_hex_unit u_hex (.hx(hx));

  // data code is caught while reset is held and frozen until the next one
  logic ascii_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      ascii_reg <= DATA_CODE_ASCII;
  end

  // ---------------- command receive ----------------
  logic [3:0] pos_reg;
  logic half_reg;
  logic [7:0] hold_reg;
  logic err_reg;
  logic done_reg;
  logic cmd_valid_reg;
  logic cmd_err_reg;
  logic [7:0] cmd_mem [plfc_pkg::CMD_BYTES];
  logic rx_fire;
  logic [7:0] rx_byte;
  logic [3:0] rx_slot;

  // text frames put the device code before the head number, both top first
  function automatic logic [3:0] slot_of(input logic [3:0] p,
                                         input logic asc);
    slot_of = p;
    if (asc) begin
      case (p)
        plfc_pkg::SLOT_TMR_L: slot_of = plfc_pkg::SLOT_TMR_H;
        plfc_pkg::SLOT_TMR_H: slot_of = plfc_pkg::SLOT_TMR_L;
        plfc_pkg::SLOT_HEAD0: slot_of = plfc_pkg::SLOT_DEV_H;
        plfc_pkg::SLOT_HEAD1: slot_of = plfc_pkg::SLOT_DEV_L;
        plfc_pkg::SLOT_HEAD2: slot_of = plfc_pkg::SLOT_HEAD3;
        plfc_pkg::SLOT_HEAD3: slot_of = plfc_pkg::SLOT_HEAD2;
        plfc_pkg::SLOT_DEV_L: slot_of = plfc_pkg::SLOT_HEAD1;
        plfc_pkg::SLOT_DEV_H: slot_of = plfc_pkg::SLOT_HEAD0;
        default: slot_of = p;
      endcase
    end
  endfunction

  assign hx.chars_in = {hold_reg, RX_DATA};
  assign rx_fire = RX_VALID && (!ascii_reg || half_reg);
  assign rx_byte = ascii_reg ? hx.byte_out : RX_DATA;
  assign rx_slot = slot_of(pos_reg, ascii_reg);

  always_ff @(posedge CORE_CLK) begin
    if (RX_VALID && ascii_reg && !half_reg)
      hold_reg <= RX_DATA;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      for (int i = 0; i < plfc_pkg::CMD_BYTES; i++)
        cmd_mem[i] <= 8'h00;
    end else if (rx_fire) begin
      cmd_mem[rx_slot] <= rx_byte;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pos_reg <= 4'h0;
      half_reg <= 1'h0;
      err_reg <= 1'h0;
      done_reg <= 1'h0;
    end else begin
      done_reg <= 1'h0;
      if (done_reg)
        err_reg <= 1'h0;
      if (RX_VALID) begin
        if (ascii_reg && !half_reg) begin
          half_reg <= 1'h1;
        end else begin
          half_reg <= 1'h0;
          if (ascii_reg && !hx.ok)
            err_reg <= 1'h1;
          if (pos_reg == plfc_pkg::SLOT_PAD) begin
            pos_reg <= 4'h0;
            done_reg <= 1'h1;
          end else begin
            pos_reg <= pos_reg + 4'h1;
          end
        end
        // a short frame is dropped, so the next one starts aligned
        if (RX_LAST && !(rx_fire && pos_reg == plfc_pkg::SLOT_PAD)) begin
          pos_reg <= 4'h0;
          half_reg <= 1'h0;
          err_reg <= 1'h0;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cmd_valid_reg <= 1'h0;
      cmd_err_reg <= 1'h0;
    end else begin
      cmd_valid_reg <= done_reg;
      if (done_reg)
        cmd_err_reg <= err_reg ||
          cmd_mem[plfc_pkg::SLOT_SUB] != plfc_pkg::SUB_BIT_READ ||
          cmd_mem[plfc_pkg::SLOT_STN] != plfc_pkg::STATION_LOCAL;
    end
  end

  assign CMD_VALID = cmd_valid_reg;
  assign CMD_ERR = cmd_err_reg;
  assign CMD_SUBHDR = cmd_mem[plfc_pkg::SLOT_SUB];
  assign CMD_STATION = cmd_mem[plfc_pkg::SLOT_STN];
  assign CMD_TIMER = {cmd_mem[plfc_pkg::SLOT_TMR_H],
                      cmd_mem[plfc_pkg::SLOT_TMR_L]};
  assign CMD_HEAD = {cmd_mem[plfc_pkg::SLOT_HEAD3],
                     cmd_mem[plfc_pkg::SLOT_HEAD2],
                     cmd_mem[plfc_pkg::SLOT_HEAD1],
                     cmd_mem[plfc_pkg::SLOT_HEAD0]};
  assign CMD_DEVICE = {cmd_mem[plfc_pkg::SLOT_DEV_H],
                       cmd_mem[plfc_pkg::SLOT_DEV_L]};
  assign CMD_POINTS = cmd_mem[plfc_pkg::SLOT_CNT];

  // ---------------- monitoring timer ----------------
  logic [TW-1:0] tick_reg;
  logic [15:0] wait_reg;
  logic run_reg;
  logic timeout_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tick_reg <= '0;
      wait_reg <= 16'h0000;
      run_reg <= 1'h0;
      timeout_reg <= 1'h0;
    end else begin
      timeout_reg <= 1'h0;
      if (cmd_valid_reg && !cmd_err_reg) begin
        // zero keeps run low: the adapter waits for ever
        run_reg <= (CMD_TIMER != 16'h0000);
        wait_reg <= CMD_TIMER;
        tick_reg <= '0;
      end else if (RESP_START) begin
        run_reg <= 1'h0;
      end else if (run_reg) begin
        if (tick_reg == TW'(TICK_CYCLES - 1)) begin
          tick_reg <= '0;
          wait_reg <= wait_reg - 16'h0001;
          if (wait_reg == 16'h0001) begin
            run_reg <= 1'h0;
            timeout_reg <= 1'h1;
          end
        end else begin
          tick_reg <= tick_reg + TW'(1);
        end
      end
    end
  end

  assign TIMEOUT = timeout_reg;

  // ---------------- response transmit ----------------
  plfc_pkg::plfc_tx_state_type st_reg, st_next;
  plfc_pkg::plfc_mode_type mode_reg;
  logic [1:0] sub_reg, sub_next;
  logic [3:0] bp_reg, bp_next;
  logic [POINT_W-1:0] rem_reg, rem_next;
  logic [15:0] w_reg, w_next;
  logic wv_reg, wv_next;
  logic [7:0] code_reg;
  logic [7:0] det_reg;
  logic [7:0] rsub_reg;
  logic tx_valid_reg;
  logic [7:0] tx_data_reg;
  logic tx_last_reg;
  logic can_emit;
  logic emit;
  logic [7:0] ed;
  logic el;
  logic [7:0] fb;
  logic field_done;
  logic word_done;

  assign can_emit = !tx_valid_reg || TX_READY;

  always_comb begin
    st_next = st_reg;
    sub_next = sub_reg;
    bp_next = bp_reg;
    rem_next = rem_reg;
    w_next = w_reg;
    wv_next = wv_reg;
    emit = 1'h0;
    ed = plfc_pkg::PAD_BYTE;
    el = 1'h0;
    DATA_REQ = 1'h0;
    field_done = 1'h0;
    word_done = 1'h0;
    case (st_reg)
      plfc_pkg::S_SUB: fb = rsub_reg;
      plfc_pkg::S_CODE: fb = code_reg;
      plfc_pkg::S_FAULT: fb = det_reg;
      default: fb = plfc_pkg::PAD_BYTE;
    endcase
    hx.byte_in = fb;
    if (st_reg == plfc_pkg::S_DATA)
      hx.byte_in = sub_reg[1] ? w_reg[7:0] : w_reg[15:8];
    case (st_reg)
      plfc_pkg::S_IDLE: begin
        if (RESP_START) begin
          st_next = plfc_pkg::S_SUB;
          sub_next = 2'h0;
          bp_next = 4'h0;
          wv_next = 1'h0;
          rem_next = RESP_POINTS;
        end
      end
      plfc_pkg::S_SUB, plfc_pkg::S_CODE, plfc_pkg::S_FAULT,
      plfc_pkg::S_PAD: begin
        if (can_emit) begin
          emit = 1'h1;
          field_done = !ascii_reg || sub_reg[0];
          if (ascii_reg)
            ed = sub_reg[0] ? hx.chars_out[7:0] : hx.chars_out[15:8];
          else
            ed = fb;
          sub_next = field_done ? 2'h0 : 2'h1;
          if (field_done) begin
            case (st_reg)
              plfc_pkg::S_SUB: st_next = plfc_pkg::S_CODE;
              plfc_pkg::S_CODE: begin
                if (code_reg == plfc_pkg::CODE_DETAIL)
                  st_next = plfc_pkg::S_FAULT;
                else if (code_reg == plfc_pkg::CODE_OK && rem_reg != '0)
                  st_next = plfc_pkg::S_DATA;
                else begin
                  st_next = plfc_pkg::S_IDLE;
                  el = 1'h1;
                end
              end
              plfc_pkg::S_FAULT: st_next = plfc_pkg::S_PAD;
              default: begin
                st_next = plfc_pkg::S_IDLE;
                el = 1'h1;
              end
            endcase
          end
        end
      end
      plfc_pkg::S_DATA: begin
        if (!wv_reg) begin
          DATA_REQ = 1'h1;
          if (DATA_VALID) begin
            w_next = DATA_WORD;
            wv_next = 1'h1;
          end
        end else if (can_emit) begin
          emit = 1'h1;
          if (mode_reg == plfc_pkg::MODE_BIT1) begin
            if (ascii_reg) begin
              ed = w_reg[bp_reg] ? plfc_pkg::ASC_ONE : plfc_pkg::ASC_ZERO;
              bp_next = bp_reg + 4'h1;
              rem_next = rem_reg - POINT_W'(1);
              word_done = (bp_reg == 4'hF);
            end else begin
              // first point in the high nibble; an odd tail pads with 0
              ed = {3'h0, w_reg[bp_reg], 3'h0,
                    (rem_reg > POINT_W'(1)) && w_reg[bp_reg + 4'h1]};
              bp_next = bp_reg + 4'h2;
              rem_next = (rem_reg > POINT_W'(1)) ?
                         rem_reg - POINT_W'(2) : '0;
              word_done = (bp_reg[3:1] == 3'h7);
            end
            if (word_done)
              wv_next = 1'h0;
          end else begin
            if (ascii_reg) begin
              ed = sub_reg[0] ? hx.chars_out[7:0] : hx.chars_out[15:8];
              word_done = (sub_reg == 2'h3);
            end else begin
              ed = sub_reg[0] ? w_reg[15:8] : w_reg[7:0];
              word_done = sub_reg[0];
            end
            sub_next = word_done ? 2'h0 : sub_reg + 2'h1;
            if (word_done) begin
              wv_next = 1'h0;
              rem_next = rem_reg - POINT_W'(1);
            end
          end
          if (rem_next == '0) begin
            st_next = plfc_pkg::S_IDLE;
            el = 1'h1;
            wv_next = 1'h0;
            bp_next = 4'h0;
            sub_next = 2'h0;
          end
        end
      end
      default: st_next = plfc_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_reg <= plfc_pkg::S_IDLE;
      sub_reg <= 2'h0;
      bp_reg <= 4'h0;
      rem_reg <= '0;
      w_reg <= 16'h0000;
      wv_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      sub_reg <= sub_next;
      bp_reg <= bp_next;
      rem_reg <= rem_next;
      w_reg <= w_next;
      wv_reg <= wv_next;
    end
  end

  // out-of-range codes are replaced so the wire never carries an illegal one
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      code_reg <= plfc_pkg::CODE_OK;
      det_reg <= plfc_pkg::DETAIL_FALLBACK;
      rsub_reg <= 8'h00;
      mode_reg <= plfc_pkg::MODE_BIT1;
    end else if (st_reg == plfc_pkg::S_IDLE && RESP_START) begin
      if (RESP_CODE == plfc_pkg::CODE_OK ||
          (RESP_CODE >= plfc_pkg::CODE_MIN &&
           RESP_CODE <= plfc_pkg::CODE_MAX))
        code_reg <= RESP_CODE;
      else
        code_reg <= plfc_pkg::CODE_FALLBACK;
      if (RESP_DETAIL >= plfc_pkg::DETAIL_MIN &&
          RESP_DETAIL <= plfc_pkg::DETAIL_MAX)
        det_reg <= RESP_DETAIL;
      else
        det_reg <= plfc_pkg::DETAIL_FALLBACK;
      rsub_reg <= RESP_SUBHDR;
      mode_reg <= plfc_pkg::plfc_mode_type'(RESP_MODE);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tx_valid_reg <= 1'h0;
      tx_data_reg <= 8'h00;
      tx_last_reg <= 1'h0;
    end else if (emit) begin
      tx_valid_reg <= 1'h1;
      tx_data_reg <= ed;
      tx_last_reg <= el;
    end else if (TX_READY) begin
      tx_valid_reg <= 1'h0;
    end
  end

  assign TX_VALID = tx_valid_reg;
  assign TX_DATA = tx_data_reg;
  assign TX_LAST = tx_last_reg;
  assign RESP_BUSY = (st_reg != plfc_pkg::S_IDLE);

endmodule

/* File: plfc_link_field_codec_sva.sv */
`timescale 1ns/1ps
module plfc_codec_sva #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic DATA_CODE_ASCII,
  input wire logic CMD_VALID,
  input wire logic CMD_ERR,
  input wire logic [7:0] CMD_SUBHDR,
  input wire logic [7:0] CMD_STATION,
  input wire logic [15:0] CMD_TIMER,
  input wire logic TIMEOUT,
  input wire logic RESP_START,
  input wire logic [7:0] RESP_SUBHDR,
  input wire logic RESP_BUSY,
  input wire logic DATA_REQ,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_LAST
);
  logic [31:0] since_cmd_reg;

  // restarts on every command, so an expiry can be tied to its cause
  always_ff @(posedge CORE_CLK) begin
    if (RST)
      since_cmd_reg <= 32'h0;
    else if (CMD_VALID)
      since_cmd_reg <= 32'h1;
    else
      since_cmd_reg <= since_cmd_reg + 32'h1;
  end

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_station_err: assert property (
    CMD_VALID && CMD_STATION != 8'hFF |-> CMD_ERR)
    else $error("station other than local accepted");
  a_subhdr_err: assert property (
    CMD_VALID && CMD_SUBHDR != 8'h00 |-> CMD_ERR)
    else $error("wrong subheader accepted");
  a_cmd_pulse: assert property (
    CMD_VALID |=> !CMD_VALID)
    else $error("command strobe longer than one cycle");
  a_timeout_due: assert property (
    TIMEOUT |-> !CMD_ERR && CMD_TIMER != 16'h0000 &&
      since_cmd_reg == 32'(32'(CMD_TIMER) * TICK_CYCLES + 1))
    else $error("timeout at wrong moment");
  a_resp_launch: assert property (
    RESP_START && !RESP_BUSY |=> RESP_BUSY ##1 TX_VALID)
    else $error("response did not start on time");
  a_subhdr_first: assert property (
    RESP_START && !RESP_BUSY |-> ##2 TX_DATA == (DATA_CODE_ASCII ?
      hex_char(4'($past(RESP_SUBHDR, 2) >> 4)) : $past(RESP_SUBHDR, 2)))
    else $error("first response unit is not the subheader");
  a_tx_hold: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST))
    else $error("output unit changed while stalled");
  a_text_upper: assert property (
    DATA_CODE_ASCII && TX_VALID |->
      TX_DATA inside {[8'h30:8'h39], [8'h41:8'h46]})
    else $error("text output is not an upper case hex digit");
  a_data_busy: assert property (
    DATA_REQ |-> RESP_BUSY)
    else $error("data requested outside a response");
endmodule

bind plfc_link_field_codec plfc_codec_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .CORE_CLK, .RST, .DATA_CODE_ASCII, .CMD_VALID, .CMD_ERR, .CMD_SUBHDR,
  .CMD_STATION, .CMD_TIMER, .TIMEOUT, .RESP_START, .RESP_SUBHDR,
  .RESP_BUSY, .DATA_REQ, .TX_VALID, .TX_READY, .TX_DATA, .TX_LAST
);

/* File: plfc_host_model.sv */
`timescale 1ns/1ps
module plfc_host_model (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [7:0] got[$];
  logic slow;
  logic [1:0] ph;
  int n_last;
  int last_at;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_last = 1'b0;
    tx_ready = 1'b1;
    slow = 1'b0;
    ph = 2'h0;
    n_last = 0;
    last_at = 0;
  end

  // frame goes out in order, subheader first, one unit per cycle
  task automatic send(input logic [7:0] q[$]);
    for (int i = 0; i < q.size(); i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
      rx_last <= (i == q.size() - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~q[q.size() - 1];
  endtask

  // slow sink accepts one cycle in four to exercise the stall path
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    tx_ready <= !slow || ph == 2'h0;
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      if (tx_last) begin
        last_at = got.size();
        n_last++;
      end
    end
  end
endmodule

/* File: plfc_link_field_codec_bench.sv */
`timescale 1ns/1ps
module plfc_link_field_codec_bench;
  logic clk, rst, asc, rx_valid, rx_last, resp_start, data_valid;
  logic cmd_valid, cmd_err, timeout, busy, data_req, tx_valid, tx_ready;
  logic tx_last;
  logic [7:0] rx_data, cmd_sub, cmd_stn, cmd_pts, tx_data;
  logic [7:0] resp_sub, resp_code, resp_det;
  logic [15:0] cmd_tmr, cmd_dev, data_word;
  logic [31:0] cmd_head;
  logic [1:0] resp_mode;
  logic [8:0] resp_pts;
  logic [15:0] words[$];
  int seed = 80;
  int widx, n_cmd, n_to, cycles, mismatches, n_checks;
  logic err_seen;
  logic [7:0] codes[6] = '{8'h00, 8'h50, 8'h60, 8'h70, 8'h4F, 8'h01};

  plfc_link_field_codec #(.TICK_CYCLES(4), .POINT_W(9)) u_dut (
    .CORE_CLK(clk), .RST(rst), .DATA_CODE_ASCII(asc), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_LAST(rx_last), .CMD_VALID(cmd_valid),
    .CMD_ERR(cmd_err), .CMD_SUBHDR(cmd_sub), .CMD_STATION(cmd_stn),
    .CMD_TIMER(cmd_tmr), .CMD_HEAD(cmd_head), .CMD_DEVICE(cmd_dev),
    .CMD_POINTS(cmd_pts), .TIMEOUT(timeout), .RESP_START(resp_start),
    .RESP_SUBHDR(resp_sub), .RESP_CODE(resp_code), .RESP_DETAIL(resp_det),
    .RESP_MODE(resp_mode), .RESP_POINTS(resp_pts), .RESP_BUSY(busy),
    .DATA_REQ(data_req), .DATA_VALID(data_valid), .DATA_WORD(data_word),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .TX_LAST(tx_last));

  plfc_host_model u_host (.clk(clk), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    asc = 1'b0;
    resp_start = 1'b0;
    {resp_sub, resp_code, resp_det, resp_mode, resp_pts} = '0;
    data_valid = 1'b0;
    data_word = 16'h0000;
  end

  // data source stalls at random so the request must be held
  always @(posedge clk) begin
    cycles++;
    if (cmd_valid) begin
      n_cmd++;
      err_seen = cmd_err;
    end
    if (timeout)
      n_to++;
    if (data_req && data_valid)
      widx = widx + 1;
    data_valid <= widx < words.size() && ($random(seed) & 3) != 0;
    data_word <= (widx < words.size()) ? words[widx] : ~data_word;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] hexc(input int n);
    return (n < 10) ? 8'(8'h30 + n) : 8'(8'h37 + n);
  endfunction

  // text: hex digits top first; binary: whole bytes low first
  function automatic void put(inout logic [7:0] q[$], input int v, nib);
    for (int i = 0; i < nib; i++)
      if (asc) q.push_back(hexc((v >> (4 * (nib - 1 - i))) & 15));
      else if (i < nib / 2) q.push_back(8'((v >> (8 * i)) & 255));
  endfunction

  task automatic do_reset(input logic a);
    @(posedge clk);
    rst <= 1'b1;
    asc <= a;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic run_cmd(input int stn, tmr, head, input bit bad, cut);
    logic [7:0] q[$];
    int c0, t0, k;
    bit err;
    c0 = n_cmd;
    t0 = n_to;
    err = bad || stn != 8'hFF;
    put(q, 0, 2);
    put(q, stn, 2);
    put(q, tmr, 4);
    if (asc) put(q, 16'h4D20, 4);
    put(q, head, 8);
    if (!asc) put(q, 16'h4D20, 4);
    put(q, 8, 2);
    put(q, 0, 2);
    // text: lower-case timer digit; binary: subheader other than 00
    if (bad) q[asc ? 7 : 0] = asc ? 8'h61 : 8'h01;
    if (cut)
      u_host.send(q[0:4]);
    else
      u_host.send(q);
    for (k = 0; k < 20 && n_cmd == c0; k++) @(posedge clk);
    chk("cmd_count", cut ? c0 : c0 + 1, n_cmd);
    if (cut) return;
    chk("cmd_err", 32'(err), 32'(err_seen));
    repeat ((tmr ? tmr * 4 : 40) + 4) @(posedge clk);
    chk("timeouts", 32'(tmr != 0 && !err), n_to - t0);
    if (bad) return;
    chk("subhdr", 0, cmd_sub);
    chk("station", stn, cmd_stn);
    chk("timer", tmr, cmd_tmr);
    chk("head", head, cmd_head);
    chk("device", 16'h4D20, cmd_dev);
    chk("points", 8, cmd_pts);
  endtask

  task automatic run_resp(input int m, pts, code, det);
    logic [7:0] e[$];
    int c, l0, k;
    words = {};
    repeat ((m == 0) ? (pts + 15) / 16 : pts) words.push_back($random(seed));
    widx = 0;
    u_host.got = {};
    u_host.slow = $random(seed) & 1;
    l0 = u_host.n_last;
    for (k = 0; k < 50 && busy !== 1'b0; k++) @(posedge clk);
    resp_sub <= $random(seed);
    resp_code <= code;
    resp_det <= det;
    resp_mode <= m;
    resp_pts <= pts;
    resp_start <= 1'b1;
    @(posedge clk);
    resp_start <= 1'b0;
    c = (code == 0 || code inside {[8'h50:8'h60]}) ? code : 8'h50;
    put(e, resp_sub, 2);
    put(e, c, 2);
    if (c == 8'h5B) begin
      put(e, det inside {[8'h10:8'h18]} ? det : 8'h10, 2);
      put(e, 0, 2);
    end
    for (int i = 0; c == 0 && i < pts; i++)
      if (m != 0) put(e, words[i], 4);
      else if (asc) e.push_back(words[i / 16][i % 16] ? 8'h31 : 8'h30);
      else if (i % 2 == 0) e.push_back({3'b000, words[i / 16][i % 16],
        3'b000, (i + 1 < pts) && words[(i + 1) / 16][(i + 1) % 16]});
    for (k = 0; k < 3000 && u_host.n_last == l0; k++) @(posedge clk);
    chk("resp_len", e.size(), u_host.got.size());
    chk("last_at", e.size(), u_host.last_at);
    foreach (e[i]) chk("resp_unit", e[i], u_host.got[i]);
  endtask

  initial begin
    for (int a = 0; a < 2; a++) begin
      do_reset(a[0]);
      run_cmd(8'hFF, 16'h000A, 100, 0, 0);
      run_cmd(8'hFE, 1, $random(seed), 0, 0);
      run_cmd(8'hFF, 1, $random(seed), 1, 0);
      run_cmd(8'hFF, 1, $random(seed), 0, 1);
      run_cmd(8'hFF, 0, $random(seed), 0, 0);
      foreach (codes[j])
        run_resp(0, 0, codes[j], 0);
      run_resp(0, 0, 8'h5B, 8'h12);
      run_resp(0, 0, 8'h5B, 8'h30);
      run_resp(0, 5, 0, 0);
      run_resp(0, 17, 0, 0);
      run_resp(1, 2, 0, 0);
      run_resp(2, 3, 0, 0);
      $display("data code %0d tests done", a);
    end
    results();
  end
endmodule
